// file: core/line_ctl_pkg.sv
// line_ctl_pkg: offsets, field positions, reset values and decoded modes
// of the line interface control registers.
// assumes: compiled before any file that imports it.
package line_ctl_pkg;

	// ********************************
	// register map
	// ********************************
	localparam logic [7:0] gain_monitor_off    = 8'h00;
	localparam logic [7:0] termination_off     = 8'h01;
	localparam logic [7:0] gain_monitor_rst    = 8'h0f;
	localparam logic [7:0] termination_rst     = 8'h08;

	// ********************************
	// field positions
	// ********************************
	localparam int ring_squelch_bit       = 7;
	localparam int rx_gain_lsb            = 4;
	localparam int mon_rx_lsb             = 2;
	localparam int mon_tx_lsb             = 0;
	localparam int full_scale_bit         = 7;
	localparam int dc_term_off_bit        = 6;
	localparam int on_hook_speed_bit      = 5;
	localparam int ac_term_bit            = 4;
	localparam int dc_volt_lsb            = 2;
	localparam int ringer_imp_bit         = 1;
	localparam int ringer_thr_bit         = 0;

	// ********************************
	// decoded settings
	// ********************************
	typedef enum logic [2:0] {gain_0db, gain_3db, gain_6db, gain_9db, gain_12db} rx_gain_t;
	typedef enum logic [1:0] {mon_step0, mon_step1, mon_step2, mon_mute} mon_level_t;
	typedef enum logic [1:0] {dc_low_volt, dc_japan, dc_usa, dc_current_limit} dc_mode_t;

endpackage

// file: core/line_ctl_if.sv
// line_ctl_if: carries the decoded settings from the decoder to the top.
// assumes: the top drives the raw registers, one decoder drives the decoded settings the top reads.
`timescale 1ns/10ps
interface line_ctl_if;
	import line_ctl_pkg::*;
	logic       [7:0] gain_reg;
	logic       [7:0] term_reg;
	rx_gain_t         rx_gain;
	mon_level_t       mon_rx;
	mon_level_t       mon_tx;
	dc_mode_t         dc_mode;
	modport dec (input gain_reg, input term_reg, output rx_gain, output mon_rx,
		output mon_tx, output dc_mode);
	modport top (output gain_reg, output term_reg, input rx_gain, input mon_rx,
		input mon_tx, input dc_mode);
endinterface

// file: core/line_ctl_decode.sv
// line_ctl_decode: turns the raw register fields into mode selections.
// assumes: purely combinational; the top registers the results.
`timescale 1ns/10ps
module line_ctl_decode
	import line_ctl_pkg::*;
(
	line_ctl_if.dec    cfg
);

	// ********************************
	// field decode
	// ********************************
	function automatic mon_level_t mon_decode(input logic [1:0] code);
		mon_decode = mon_level_t'(code);
	endfunction

	always_comb
	begin
		// any code with the top bit set means the largest gain
		if (cfg.gain_reg[rx_gain_lsb+2])
			cfg.rx_gain = gain_12db; // [R2]
		else
			cfg.rx_gain = rx_gain_t'({1'b0, cfg.gain_reg[rx_gain_lsb +: 2]}); // [R2]
		cfg.mon_rx  = mon_decode(cfg.gain_reg[mon_rx_lsb +: 2]); // [R3]
		cfg.mon_tx  = mon_decode(cfg.gain_reg[mon_tx_lsb +: 2]); // [R4]
		cfg.dc_mode = dc_mode_t'(cfg.term_reg[dc_volt_lsb +: 2]); // [R10]
	end

endmodule

// file: core/line_ctl_regs.sv
// line_ctl_regs: the two line interface control registers and the
// mode outputs they steer toward the analog line interface.
// assumes: single clock, synchronous reset, simple strobe register port.
// Operation
// [R1] host doing own ring detect sets squelch, clears after each reversal
// [R2] receive gain code picks 0/3/6/9/12 dB off-hook, other set on-hook
// [R3] monitor receive level 0, -6, -12 dB, code 11 mutes
// [R4] monitor transmit level -18, -24, -30 dB, code 11 mutes
// [R5] full-scale bit raises converter full scale to at least 3.2 dBm
// [R6] software sets full scale only while ac termination bit is zero
// [R7] software keeps dc termination off at zero while on-hook
// [R8] on-hook speed bit: 0 fast, 1 slow controlled on-hook
// [R9] ac termination bit: 0 real, 1 complex impedance
// [R10] dc voltage field picks low, japan, usa or current-limit mode
// [R11] ringer impedance bit: 0 maximum, 1 synthesized
// [R12] ringer threshold bit: 0 lower window, 1 higher window
// [R13] reset loads defaults; writes update all fields next cycle
//
// Design decisions made here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module line_ctl_regs
	import line_ctl_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       srst,
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr,
	input  wire logic       rd,
	output logic      [7:0] rdata,
	output logic            ring_squelch,
	output rx_gain_t        analog_rx_gain,
	output mon_level_t      monitor_rx_level,
	output mon_level_t      monitor_tx_level,
	output logic            full_scale_high,
	output logic            dc_termination_off,
	output logic            on_hook_speed,
	output logic            ac_termination_complex,
	output dc_mode_t        dc_termination_voltage,
	output logic            ringer_impedance,
	output logic            ringer_threshold
);

	logic [7:0] gain_r;
	logic [7:0] term_r;

	line_ctl_if cfg ();

	assign cfg.gain_reg = gain_r;
	assign cfg.term_reg = term_r;

	line_ctl_decode u_decode
	(
		.cfg (cfg)
	);

	// ********************************
	// register writes
	// ********************************
	// software ordering of squelch, full scale and dc-off is trusted, not enforced
	always_ff @(posedge clk)
	begin
		if (srst)
			gain_r <= gain_monitor_rst; // [R13]
		else if (wr && addr == gain_monitor_off)
			gain_r <= wdata; // [R13]
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			term_r <= termination_rst; // [R13]
		else if (wr && addr == termination_off)
			term_r <= wdata; // [R13]
	end

	// ********************************
	// read port
	// ********************************
	// unmapped offsets read as zero
	always_ff @(posedge clk)
	begin
		if (srst)
			rdata <= 8'h00;
		else if (rd)
			case (addr)
				gain_monitor_off: rdata <= gain_r;
				termination_off:  rdata <= term_r;
				default:          rdata <= 8'h00;
			endcase
		else
			rdata <= 8'h00;
	end

	// ********************************
	// mode outputs
	// ********************************
	// outputs lag the register by one cycle so every pin leaves a flop
	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			ring_squelch           <= 1'b0;
			analog_rx_gain         <= gain_0db;
			monitor_rx_level       <= mon_mute;
			monitor_tx_level       <= mon_mute;
			full_scale_high        <= 1'b0;
			dc_termination_off     <= 1'b0;
			on_hook_speed          <= 1'b0;
			ac_termination_complex <= 1'b0;
			dc_termination_voltage <= dc_usa;
			ringer_impedance       <= 1'b0;
			ringer_threshold       <= 1'b0;
		end
		else
		begin
			ring_squelch           <= gain_r[ring_squelch_bit]; // [R1]
			analog_rx_gain         <= cfg.rx_gain; // [R2]
			monitor_rx_level       <= cfg.mon_rx; // [R3]
			monitor_tx_level       <= cfg.mon_tx; // [R4]
			full_scale_high        <= term_r[full_scale_bit]; // [R5]
			dc_termination_off     <= term_r[dc_term_off_bit]; // [R7]
			on_hook_speed          <= term_r[on_hook_speed_bit]; // [R8]
			ac_termination_complex <= term_r[ac_term_bit]; // [R9]
			dc_termination_voltage <= cfg.dc_mode; // [R10]
			ringer_impedance       <= term_r[ringer_imp_bit]; // [R11]
			ringer_threshold       <= term_r[ringer_thr_bit]; // [R12]
		end
	end

endmodule

// file: verif/line_ctl_regs_sva.sv
// line_ctl_regs_sva: assertions on the register port and mode outputs.
// assumes: bound to line_ctl_regs, one clock, sync reset.
`timescale 1ns/10ps
module line_ctl_regs_sva
	import line_ctl_pkg::*;
(
	input wire logic       clk,
	input wire logic       srst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	input wire logic       ring_squelch,
	input wire rx_gain_t   analog_rx_gain,
	input wire mon_level_t monitor_rx_level,
	input wire mon_level_t monitor_tx_level,
	input wire logic       full_scale_high,
	input wire logic       dc_termination_off,
	input wire logic       on_hook_speed,
	input wire logic       ac_termination_complex,
	input wire dc_mode_t   dc_termination_voltage,
	input wire logic       ringer_impedance,
	input wire logic       ringer_threshold
);
	// ****
	// properties
	// ****
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	wire logic [7:0] t = {full_scale_high, dc_termination_off, on_hook_speed,
		ac_termination_complex, dc_termination_voltage, ringer_impedance, ringer_threshold};
	sequence wr_g; wr && addr == gain_monitor_off; endsequence
	sequence wr_t; wr && addr == termination_off; endsequence
	AST_SQUELCH: assert property (wr_g |-> ##2 ring_squelch == $past(wdata[7], 2))
		else $error("squelch");
	AST_GAIN: assert property (wr_g |-> ##2 analog_rx_gain ==
		($past(wdata[6], 2) ? 3'h4 : {1'b0, $past(wdata[5:4], 2)})) else $error("gain");
	AST_MON_RX: assert property (wr_g |-> ##2 monitor_rx_level == $past(wdata[3:2], 2))
		else $error("mon rx");
	AST_MON_TX: assert property (wr_g |-> ##2 monitor_tx_level == $past(wdata[1:0], 2))
		else $error("mon tx");
	AST_TERM: assert property (wr_t |->
		##2 t == $past(wdata, 2)) else $error("term");
	AST_HOLD: assert property (!$past(wr, 2) |-> $stable(t)) else $error("hold");
	AST_RD_TERM: assert property (rd && addr == termination_off |=> rdata == t)
		else $error("rd term");
	AST_RD_GAIN: assert property (rd && addr == gain_monitor_off |=>
		rdata[7] == ring_squelch && rdata[3:0] == {monitor_rx_level, monitor_tx_level})
		else $error("rd gain");
	AST_RD_UNMAP: assert property (rd && addr > 8'h01 |=> rdata == 8'h00) else $error("unmap");
	AST_RD_IDLE: assert property (!$past(rd) |-> rdata == 8'h00) else $error("rd idle");
endmodule
bind line_ctl_regs line_ctl_regs_sva line_ctl_regs_sva_i
(
	.clk                    (clk),
	.srst                   (srst),
	.addr                   (addr),
	.wdata                  (wdata),
	.wr                     (wr),
	.rd                     (rd),
	.rdata                  (rdata),
	.ring_squelch           (ring_squelch),
	.analog_rx_gain         (analog_rx_gain),
	.monitor_rx_level       (monitor_rx_level),
	.monitor_tx_level       (monitor_tx_level),
	.full_scale_high        (full_scale_high),
	.dc_termination_off     (dc_termination_off),
	.on_hook_speed          (on_hook_speed),
	.ac_termination_complex (ac_termination_complex),
	.dc_termination_voltage (dc_termination_voltage),
	.ringer_impedance       (ringer_impedance),
	.ringer_threshold       (ringer_threshold)
);

// file: verif/tb_line_ctl_regs.sv
// tb_line_ctl_regs: directed register and mode output checks.
// assumes: the checker is bound; no waits on handshakes exist here.
`timescale 1ns/10ps
module tb_line_ctl_regs;
	import line_ctl_pkg::*;
	logic clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, t, g;
	logic ring_squelch, full_scale_high, dc_termination_off, on_hook_speed;
	logic ac_termination_complex, ringer_impedance, ringer_threshold;
	logic [2:0] analog_rx_gain;
	logic [1:0] monitor_rx_level, monitor_tx_level, dc_termination_voltage;
	int n_fail = 0, checks_done = 0;
	always #2.5 clk = ~clk;
	line_ctl_regs line_ctl_regs_i
	(
		.clk                    (clk),
		.srst                   (srst),
		.addr                   (addr),
		.wdata                  (wdata),
		.wr                     (wr),
		.rd                     (rd),
		.rdata                  (rdata),
		.ring_squelch           (ring_squelch),
		.analog_rx_gain         (analog_rx_gain),
		.monitor_rx_level       (monitor_rx_level),
		.monitor_tx_level       (monitor_tx_level),
		.full_scale_high        (full_scale_high),
		.dc_termination_off     (dc_termination_off),
		.on_hook_speed          (on_hook_speed),
		.ac_termination_complex (ac_termination_complex),
		.dc_termination_voltage (dc_termination_voltage),
		.ringer_impedance       (ringer_impedance),
		.ringer_threshold       (ringer_threshold)
	);
	assign t = {full_scale_high, dc_termination_off, on_hook_speed, ac_termination_complex,
		dc_termination_voltage, ringer_impedance, ringer_threshold};
	assign g = {ring_squelch, analog_rx_gain, monitor_rx_level, monitor_tx_level};
	// ****
	// tasks
	// ****
	function automatic logic [7:0] gexp(input logic [7:0] w);
		return {w[7], w[6] ? 3'h4 : {1'b0, w[5:4]}, w[3:0]};
	endfunction
	task chk(input string what, input logic [7:0] e, input logic [7:0] s);
		checks_done++;
		if (s !== e)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", what, e, s);
		end
	endtask
	task wr_reg(input logic [7:0] a, input logic [7:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		// idle edge so a following write never sets wr in the same step
		@(posedge clk);
	endtask
	// outputs of the addressed register are judged too; unmapped uses gain
	task rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] eo);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk("rdata", e, rdata);
		chk("outputs", eo, (a == termination_off) ? t : g);
		@(posedge clk);
	endtask
	task reset_defaults;
		srst <= 1'b1;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		rd_reg(gain_monitor_off, gain_monitor_rst, 8'h0f);
		rd_reg(termination_off, termination_rst, 8'h08);
	endtask
	// write then read at once, every gain and monitor code
	task gain_codes;
		logic [2:0] c;
		logic [7:0] w;
		for (int k = 0; k < 8; k++)
		begin
			c = k[2:0];
			w = {c[0], c, c[1:0], ~c[1:0]};
			wr_reg(gain_monitor_off, w);
			rd_reg(gain_monitor_off, w, gexp(w));
		end
	endtask
	// full scale only with real impedance all voltage modes
	// dc-off set only in a word software would write while off-hook
	task term_codes;
		logic [7:0] tv [4];
		tv = '{8'h00, 8'h35, 8'hca, 8'h6f};
		foreach (tv[i])
		begin
			wr_reg(termination_off, tv[i]);
			rd_reg(termination_off, tv[i], tv[i]);
		end
	endtask
	task unmapped;
		wr_reg(gain_monitor_off, 8'h5a);
		wr_reg(8'h02, 8'hff);
		wr_reg(8'hff, 8'h00);
		rd_reg(8'h02, 8'h00, gexp(8'h5a));
		rd_reg(gain_monitor_off, 8'h5a, gexp(8'h5a));
		rd_reg(termination_off, 8'h6f, 8'h6f);
	endtask
	task finish_test;
		$display("checks %0d errors %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial
	begin
		reset_defaults;
		gain_codes;
		term_codes;
		unmapped;
		reset_defaults;
		finish_test;
	end
endmodule
